/* logic/bank_addr_consts.svh */
// Address-map constants for the banked data memory address unit.
// Assumes inclusion by the package and by the design file.
`ifndef BANK_ADDR_CONSTS_SVH
`define BANK_ADDR_CONSTS_SVH
`define ADDR_W            12
`define BANK_W            4
`define OFFS_W            8
`define BANK_PTR_RESET    4'h0
`define ACC_SPLIT         8'h60
`define ACC_LOW_BANK      4'h0
`define ACC_HIGH_BANK     4'hf
`define PCL_OFFSET        8'hf9
`define PCL_BANK          4'hf
`define REG_BANK_PTR      4'h0
`define REG_LAST_ADDR     4'h4
`define REG_STATUS        4'h4
`define REG_IMPL_MASK     4'h8
`define IMPL_BANKS_RESET  16'hffff
`endif

/* logic/bank_addr_pkg.sv */
// Types for the banked data memory address unit.
// Assumes the constants header is on the include path.
`include "bank_addr_consts.svh"
package bank_addr_pkg;
  typedef struct packed {
    logic                valid;
    logic                write;
    logic                full_addr;
    logic                access_sel;
    logic [`ADDR_W-1:0]  addr;
    logic [7:0]          wdata;
  } mem_req_type;
  typedef struct packed {
    logic                valid;
    logic                write;
    logic [`ADDR_W-1:0]  addr;
    logic [7:0]          wdata;
  } ram_req_type;
endpackage

/* logic/bank_addr_unit.sv */
// Banked data memory address generation and access mapping.
// Assumes a decoder on i_clk issuing one request per cycle and a RAM
// answering reads combinationally on o_ram / i_ram_rdata.
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "bank_addr_consts.svh"
module bank_addr_unit #(
  parameter logic [15:0] IMPL_BANKS = `IMPL_BANKS_RESET
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_reset_n,
  input  wire bank_addr_pkg::mem_req_type i_req,
  input  wire logic                      i_load_bank_literal,
  input  wire logic [7:0]                i_bank_literal,
  input  wire logic                      i_extended_isa_config,
  input  wire logic [`ADDR_W-1:0]        i_remap_addr,
  output logic [`ADDR_W-1:0]             o_addr,
  output logic                           o_remap_active,
  output logic                           o_bank_unimpl,
  output logic                           o_pcl_hit,
  output logic                           o_flags_update,
  output bank_addr_pkg::ram_req_type     o_ram,
  input  wire logic [7:0]                i_ram_rdata,
  input  wire logic                      i_ram_impl,
  output logic [7:0]                     o_rdata,
  input  wire logic [3:0]                i_avs_address,
  input  wire logic                      i_avs_read,
  input  wire logic                      i_avs_write,
  input  wire logic [31:0]               i_avs_writedata,
  input  wire logic [3:0]                i_avs_byteenable,
  output logic [31:0]                    o_avs_readdata,
  output logic                           o_avs_waitrequest
);
  import bank_addr_pkg::*;

  // ----------------------------------------------------------------
  // Bank pointer
  // ----------------------------------------------------------------
  logic [`BANK_W-1:0] bank_pointer_r;
  logic               bus_bp_wr;
  logic [15:0]        impl_banks_r;
  logic               bus_impl_wr;
  logic [`ADDR_W-1:0] last_addr_r;
  logic               last_unimpl_r;

  // Literal load outranks a bus write
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bank_pointer_r <= `BANK_PTR_RESET;
    end else if (i_load_bank_literal) begin
      bank_pointer_r <= i_bank_literal[`BANK_W-1:0];
    end else if (bus_bp_wr) begin
      bank_pointer_r <= i_avs_writedata[`BANK_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Address formation
  // ----------------------------------------------------------------
  logic [`OFFS_W-1:0] offs;
  logic [`BANK_W-1:0] bank;
  logic               use_remap;
  logic [`ADDR_W-1:0] addr_nxt;

  assign offs = i_req.addr[`OFFS_W-1:0];
  assign use_remap = i_extended_isa_config && !i_req.full_addr
                     && !i_req.access_sel;

  // Full address first, then pointer, remap, access-bank map
  always_comb begin
    if (i_req.full_addr) begin
      addr_nxt = i_req.addr;
    end else if (i_req.access_sel) begin
      addr_nxt = {bank_pointer_r, offs};
    end else if (use_remap) begin
      addr_nxt = i_remap_addr;
    end else if (offs < `ACC_SPLIT) begin
      addr_nxt = {`ACC_LOW_BANK, offs};
    end else begin
      addr_nxt = {`ACC_HIGH_BANK, offs};
    end
  end

  assign bank = addr_nxt[`ADDR_W-1:`OFFS_W];
  assign o_addr = addr_nxt;
  assign o_remap_active = i_req.valid && use_remap;
  assign o_bank_unimpl = i_req.valid && !impl_banks_r[bank];
  assign o_pcl_hit = i_req.valid && bank == `PCL_BANK
                     && addr_nxt[`OFFS_W-1:0] == `PCL_OFFSET;
  assign o_flags_update = i_req.valid;

  // ----------------------------------------------------------------
  // RAM side
  // ----------------------------------------------------------------
  // Unimplemented banks never see a strobe
  always_comb begin
    o_ram.valid = i_req.valid && impl_banks_r[bank];
    o_ram.write = i_req.write && impl_banks_r[bank];
    o_ram.addr  = addr_nxt;
    o_ram.wdata = i_req.wdata;
  end

  assign o_rdata = (impl_banks_r[bank] && i_ram_impl)
                   ? i_ram_rdata : 8'h00;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      last_addr_r   <= '0;
      last_unimpl_r <= 1'b0;
    end else if (i_req.valid) begin
      last_addr_r   <= addr_nxt;
      last_unimpl_r <= !impl_banks_r[bank];
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      impl_banks_r <= IMPL_BANKS;
    end else if (bus_impl_wr) begin
      impl_banks_r <= i_avs_writedata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave, one wait state per access
  // ----------------------------------------------------------------
  logic ack_r;
  logic acc;

  assign acc = (i_avs_read || i_avs_write) && !ack_r;
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_r;
  assign bus_bp_wr = i_avs_write && ack_r && i_avs_byteenable[0]
                     && i_avs_address == `REG_BANK_PTR;
  assign bus_impl_wr = i_avs_write && ack_r && i_avs_byteenable[0]
                       && i_avs_address == `REG_IMPL_MASK;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= acc;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (acc && i_avs_read) begin
      case (i_avs_address)
        `REG_BANK_PTR: o_avs_readdata <= {28'h0, bank_pointer_r};
        `REG_STATUS:   o_avs_readdata <= {19'h0, last_unimpl_r,
                                          last_addr_r};
        `REG_IMPL_MASK: o_avs_readdata <= {16'h0, impl_banks_r};
        default:       o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks: address formation
  // ----------------------------------------------------------------
  chk_banked_addr: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_req.access_sel && !i_req.full_addr
    |-> o_addr == {bank_pointer_r, i_req.addr[`OFFS_W-1:0]})
    else $error("banked address wrong");

  chk_access_low: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !i_req.access_sel && !i_req.full_addr && !i_extended_isa_config
    && i_req.addr[`OFFS_W-1:0] < `ACC_SPLIT
    |-> o_addr == {`ACC_LOW_BANK, i_req.addr[`OFFS_W-1:0]})
    else $error("access low region wrong");

  chk_access_high: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !i_req.access_sel && !i_req.full_addr && !i_extended_isa_config
    && i_req.addr[`OFFS_W-1:0] >= `ACC_SPLIT
    |-> o_addr == {`ACC_HIGH_BANK, i_req.addr[`OFFS_W-1:0]})
    else $error("access high region wrong");

  chk_full_addr: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_req.full_addr |-> o_addr == i_req.addr)
    else $error("full address not passed");

  chk_offset_kept: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !i_req.full_addr && !use_remap
    |-> o_addr[`OFFS_W-1:0] == i_req.addr[`OFFS_W-1:0])
    else $error("operand offset not kept");

  chk_remap_sel: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    o_remap_active |-> o_addr == i_remap_addr)
    else $error("remap address not used");

  chk_remap_off: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !i_extended_isa_config || i_req.access_sel || i_req.full_addr
    |-> !o_remap_active)
    else $error("remap active outside extended mode");

  chk_pcl_decode: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_req.valid && i_req.access_sel && !i_req.full_addr
    && bank_pointer_r == `PCL_BANK
    && i_req.addr[`OFFS_W-1:0] == `PCL_OFFSET |-> o_pcl_hit)
    else $error("pc low not decoded");

  chk_pcl_only: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    o_pcl_hit |-> o_addr == {`PCL_BANK, `PCL_OFFSET})
    else $error("pc low decoded at wrong address");

  // ----------------------------------------------------------------
  // Checks: bank pointer
  // ----------------------------------------------------------------
  chk_literal_load: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_load_bank_literal
    |=> bank_pointer_r == $past(i_bank_literal[`BANK_W-1:0]))
    else $error("bank literal not loaded");

  chk_ptr_write: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    bus_bp_wr && !i_load_bank_literal
    |=> bank_pointer_r == $past(i_avs_writedata[`BANK_W-1:0]))
    else $error("bank pointer bus write lost");

  chk_bus_upper: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    ack_r && $past(i_avs_read) && $past(i_avs_address) == `REG_BANK_PTR
    |-> o_avs_readdata[31:`BANK_W] == 28'h0)
    else $error("bank pointer upper bits nonzero");

  // ----------------------------------------------------------------
  // Checks: RAM side
  // ----------------------------------------------------------------
  chk_unimpl_write: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    o_bank_unimpl |-> !o_ram.write && !o_ram.valid)
    else $error("write reached unimplemented bank");

  chk_unimpl_read: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    o_bank_unimpl |-> o_rdata == 8'h00 && o_flags_update)
    else $error("unimplemented bank read not zero");

  chk_impl_pass: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_req.valid && !o_bank_unimpl
    |-> o_ram.valid && o_ram.write == i_req.write
        && o_ram.addr == o_addr && o_ram.wdata == i_req.wdata)
    else $error("implemented bank access not passed");

  chk_hole_zero: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !i_ram_impl |-> o_rdata == 8'h00)
    else $error("unimplemented location not zero");

  chk_rdata_pass: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_req.valid && !o_bank_unimpl && i_ram_impl
    |-> o_rdata == i_ram_rdata)
    else $error("implemented location read lost");

  chk_flags_valid: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_req.valid |-> o_flags_update)
    else $error("status flags not updated");

  // ----------------------------------------------------------------
  // Checks: register bus
  // ----------------------------------------------------------------
  chk_wait_single: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("more than one wait state");

  chk_impl_write: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    bus_impl_wr |=> impl_banks_r == $past(i_avs_writedata[15:0]))
    else $error("bank mask bus write lost");
endmodule // bank_addr_unit

/* sim/bank_addr_unit_tb.sv */
// Self-checking bench for the banked address unit.
// Assumes the unit, its package and ram_model are compiled first.
`timescale 1ns/1ps
module bank_addr_unit_tb;
  import bank_addr_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, lit = 1'b0, ext = 1'b0;
  logic [7:0]  lit_val = 8'h00, ram_rd, rdata;
  logic        remap_act, unimpl, pcl, flags, ram_impl, avs_wait;
  logic        avs_rd = 1'b0, avs_wr = 1'b0;
  logic [3:0]  avs_a = 4'h0;
  logic [31:0] avs_wd = 32'h0, avs_rdd, q;
  logic [11:0] addr;
  mem_req_type req = '0;
  ram_req_type ram;
  int          err_count = 0, checks = 0;
  // Bank, full, access select, operand, expected address
  logic [29:0] rows [6] = '{{4'h3, 1'b0, 1'b1, 12'h045, 12'h345},
    {4'h3, 1'b0, 1'b0, 12'h05f, 12'h05f}, {4'h3, 1'b0, 1'b0, 12'h060, 12'hf60},
    {4'h3, 1'b0, 1'b0, 12'h0ff, 12'hfff}, {4'h3, 1'b1, 1'b1, 12'habc, 12'habc},
    {4'hf, 1'b0, 1'b1, 12'h0f9, 12'hff9}};
  always #5 clk = ~clk;
  bank_addr_unit u_dut (.i_clk(clk), .i_reset_n(rst_n), .i_req(req),
    .i_load_bank_literal(lit), .i_bank_literal(lit_val),
    .i_extended_isa_config(ext), .i_remap_addr(12'h7c3), .o_addr(addr),
    .o_remap_active(remap_act), .o_bank_unimpl(unimpl), .o_pcl_hit(pcl),
    .o_flags_update(flags), .o_ram(ram), .i_ram_rdata(ram_rd),
    .i_ram_impl(ram_impl), .o_rdata(rdata), .i_avs_address(avs_a),
    .i_avs_read(avs_rd), .i_avs_write(avs_wr), .i_avs_writedata(avs_wd),
    .i_avs_byteenable(4'hf), .o_avs_readdata(avs_rdd),
    .o_avs_waitrequest(avs_wait));
  ram_model u_ram (.i_clk(clk), .i_ram(ram), .o_rdata(ram_rd),
    .o_impl(ram_impl));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_rd <= !wr;
    avs_wr <= wr;
    avs_a <= a;
    avs_wd <= d;
    do begin
      @(posedge clk);
    end while (avs_wait !== 1'b0);
    q = avs_rdd;
    avs_rd <= 1'b0;
    avs_wr <= 1'b0;
  endtask
  task drive(input logic w, f, a, input logic [11:0] ad,
             input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, w, f, a, ad, d};
    @(negedge clk);
  endtask
  task load(input logic [7:0] v);
    @(posedge clk);
    lit <= 1'b1;
    lit_val <= v;
    @(posedge clk);
    lit <= 1'b0;
  endtask
  task test_done;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    test_done;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 4'h8, 32'h0);
    chk(q, 32'h0000ffff);
    for (int i = 0; i < 6; i++) begin
      load({4'ha, rows[i][29:26]});
      drive(1'b0, rows[i][25], rows[i][24], rows[i][23:12], 8'h00);
      chk(addr, rows[i][11:0]);
      chk(pcl, rows[i][11:0] == 12'hff9);
      chk(flags, 1'b1);
    end
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0000000f);
    bus(1'b1, 4'h0, 32'hffffff35);
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h00000005);
    drive(1'b1, 1'b0, 1'b1, 12'h045, 8'ha5);
    drive(1'b0, 1'b0, 1'b1, 12'h045, 8'h00);
    chk(rdata, 8'ha5);
    drive(1'b1, 1'b0, 1'b0, 12'h060, 8'h5a);
    drive(1'b0, 1'b0, 1'b0, 12'h060, 8'h00);
    chk(rdata, 8'h00);
    // Bank 5 switched off, write must be lost
    bus(1'b1, 4'h8, 32'h0000ffdf);
    drive(1'b1, 1'b0, 1'b1, 12'h045, 8'h11);
    chk({ram.valid, unimpl, flags}, 3'h3);
    drive(1'b0, 1'b0, 1'b1, 12'h045, 8'h00);
    chk(rdata, 8'h00);
    bus(1'b1, 4'h8, 32'h0000ffff);
    @(negedge clk);
    chk(rdata, 8'ha5);
    bus(1'b0, 4'h4, 32'h0);
    chk(q, 32'h00000545);
    bus(1'b1, 4'h2, 32'h12345678);
    bus(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    @(posedge clk);
    ext <= 1'b1;
    drive(1'b0, 1'b0, 1'b0, 12'h010, 8'h00);
    chk({remap_act, addr}, 13'h17c3);
    drive(1'b0, 1'b0, 1'b1, 12'h010, 8'h00);
    chk(addr, 12'h510);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 4'h8, 32'h0);
    chk(q, 32'h0000ffff);
    test_done;
  end
endmodule // bank_addr_unit_tb

/* sim/ram_model.sv */
// Behavioural data RAM on the far side of the address unit.
// Assumes o_ram of the unit on the same clock; reads answer at once.
`timescale 1ns/1ps
module ram_model (
  input  wire logic                       i_clk,
  input  wire bank_addr_pkg::ram_req_type i_ram,
  output logic [7:0]                      o_rdata,
  output logic                            o_impl
);
  import bank_addr_pkg::*;
  logic [7:0] mem [4096];
  logic [7:0] last_r = 8'h00;
  always_ff @(posedge i_clk) begin
    if (i_ram.valid && i_ram.write)
      mem[i_ram.addr] <= i_ram.wdata;
    if (i_ram.valid)
      last_r <= o_rdata;
  end
  // Bank 15 offsets 60-7f left unimplemented
  assign o_impl  = !(i_ram.addr[11:5] == 7'h7b);
  // Idle bus shows the complement of the last read, held while idle
  assign o_rdata = i_ram.valid ? mem[i_ram.addr] : ~last_r;
endmodule // ram_model
